// File: hw/rws_sync.sv
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module rws_sync
   import rws_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic core_domain_clock,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [rws_pkg::ADDR_W-1:0] addr,
   input wire logic [rws_pkg::DATA_W-1:0] wr_data,
   input wire logic [3:0] wr_be,
   output logic [rws_pkg::DATA_W-1:0] rd_data,
   output logic irq,
   output logic [7:0] core_byte_reg_low,
   output logic [7:0] core_byte_reg_high,
   output logic [15:0] core_halfword_reg,
   output logic core_enable,
   output logic soft_reset_request
);
   import rws_pkg::*;

   // whole state of the block except the age_low helper
   typedef struct packed {
      logic clk_meta; // first synchroniser stage of the core clock
      logic clk_sync; // second stage
      logic clk_prev; // delayed copy for edge detection
      logic [NCH-1:0] busy; // pending_sync_flags
      logic [NCH-1:0] busy_prev; // busy one cycle ago, hides a tick already in flight at acceptance
      logic [NCH-1:0][2:0] cnt; // core ticks seen per channel
      logic [7:0] sh_low; // bus-side values, read back at once
      logic [7:0] sh_high;
      logic [15:0] sh_half;
      logic sh_enable;
      logic sh_soft_reset_request; // soft_reset_bit
      logic [7:0] cr_low; // core-side copies
      logic [7:0] cr_high;
      logic [15:0] cr_half;
      logic cr_enable;
      logic reset_pulse;
      logic [NFLG-1:0] flags;
      logic [NFLG-1:0] mask;
      logic [DATA_W-1:0] rd_data;
      logic irq;
   } rws_state_t;

   rws_state_t state_reg; // registered state
   rws_state_t state_next; // next state
   logic tick; // rising edge of the core clock
   logic [NCH-1:0] done; // channels finishing this cycle
   logic ready_evt; // a data register finished syncing
   logic err_evt; // a write was discarded
   logic [NFLG-1:0] set_evt; // flag set requests

   // a write to a channel is refused while it or soft reset is busy
   function automatic logic refused(input logic [NCH-1:0] busy, input int ch);
      refused = busy[ch] | busy[CH_SOFT_RESET_REQUEST];
   endfunction : refused

   // next-state logic
   always_comb
   begin
      state_next = state_reg;
      done = '0;
      err_evt = 1'b0;
      // core clock sampled through two flops, then edge detected
      state_next.clk_meta = core_domain_clock;
      state_next.clk_sync = state_reg.clk_meta;
      state_next.clk_prev = state_reg.clk_sync;
      tick = state_reg.clk_sync & ~state_reg.clk_prev;
      state_next.reset_pulse = 1'b0;
      state_next.rd_data = '0;
      state_next.busy_prev = state_reg.busy;
      // per-channel core-side counting, all channels sharing one synchroniser
      // a tick in the first busy cycle came from a core edge before the write: skip it
      for (int k = 0; k < NCH; k++)
      begin
         if (state_reg.busy[k] && state_reg.busy_prev[k] && tick)
         begin
            if (state_reg.cnt[k] == SYNC_LAST_TICK)
            begin
               // core captured the value: ack clears busy
               done[k] = 1'b1;
               state_next.busy[k] = 1'b0;
               state_next.cnt[k] = '0;
            end
            else
            begin
               state_next.cnt[k] = state_reg.cnt[k] + 3'h1;
            end
         end
      end
      // core copies take the bus-side values on completion
      if (done[CH_LOW])
      begin
         state_next.cr_low = state_reg.sh_low;
      end
      if (done[CH_HIGH])
      begin
         state_next.cr_high = state_reg.sh_high;
      end
      if (done[CH_HALF])
      begin
         state_next.cr_half = state_reg.sh_half;
      end
      if (done[CH_EN])
      begin
         state_next.cr_enable = state_reg.sh_enable;
      end
      // only data registers raise ready
      ready_evt = |done[CH_HALF:CH_LOW];
      if (done[CH_SOFT_RESET_REQUEST])
      begin
         // peripheral reset done: hardware clears bit and flag
         state_next.reset_pulse = 1'b1;
         state_next.sh_soft_reset_request = 1'b0;
         state_next.busy = '0;
         state_next.cnt = '0;
         state_next.sh_low = RST_BYTE;
         state_next.sh_high = RST_BYTE;
         state_next.sh_half = RST_HALF;
         state_next.sh_enable = RST_ENABLE;
         state_next.cr_low = RST_BYTE;
         state_next.cr_high = RST_BYTE;
         state_next.cr_half = RST_HALF;
         state_next.cr_enable = RST_ENABLE;
         ready_evt = 1'b0;
      end
      // bus writes
      if (wr_en)
      begin
         case (addr)
            OFF_CORE:
            begin
               // low byte lane
               if (wr_be[0])
               begin
                  if (refused(state_reg.busy, CH_LOW))
                  begin
                     err_evt = 1'b1;
                  end
                  else
                  begin
                     state_next.sh_low = wr_data[7:0];
                     state_next.busy[CH_LOW] = 1'b1;
                     state_next.cnt[CH_LOW] = '0;
                  end
               end
               // high byte lane
               if (wr_be[1])
               begin
                  if (refused(state_reg.busy, CH_HIGH))
                  begin
                     err_evt = 1'b1;
                  end
                  else
                  begin
                     state_next.sh_high = wr_data[15:8];
                     state_next.busy[CH_HIGH] = 1'b1;
                     state_next.cnt[CH_HIGH] = '0;
                  end
               end
               // halfword lanes; a second byte while busy is dropped
               if (wr_be[2] || wr_be[3])
               begin
                  if (refused(state_reg.busy, CH_HALF))
                  begin
                     err_evt = 1'b1;
                  end
                  else
                  begin
                     if (wr_be[2])
                     begin
                        state_next.sh_half[7:0] = wr_data[23:16];
                     end
                     if (wr_be[3])
                     begin
                        state_next.sh_half[15:8] = wr_data[31:24];
                     end
                     state_next.busy[CH_HALF] = 1'b1;
                     state_next.cnt[CH_HALF] = '0;
                  end
               end
            end
            OFF_CTRL:
            begin
               if (wr_be[0])
               begin
                  if (refused(state_reg.busy, CH_EN))
                  begin
                     err_evt = 1'b1;
                  end
                  else
                  begin
                     // enable reads back the new value at once
                     state_next.sh_enable = wr_data[CTRL_EN_BIT];
                     state_next.busy[CH_EN] = 1'b1;
                     state_next.cnt[CH_EN] = '0;
                     // soft reset only on a one; zero has no effect
                     if (wr_data[SOFT_RESET_BIT_BIT])
                     begin
                        state_next.sh_soft_reset_request = 1'b1;
                        state_next.busy[CH_SOFT_RESET_REQUEST] = 1'b1;
                        state_next.cnt[CH_SOFT_RESET_REQUEST] = '0;
                     end
                  end
               end
            end
            OFF_FLAG:
            begin
               // write one to clear
               if (wr_be[0])
               begin
                  state_next.flags = state_reg.flags & ~wr_data[NFLG-1:0];
               end
            end
            OFF_MASK:
            begin
               if (wr_be[0])
               begin
                  state_next.mask = wr_data[NFLG-1:0];
               end
            end
            default:
            begin
               // unmapped write is ignored
            end
         endcase
      end
      // events set after the clear, so set wins
      set_evt = '0;
      set_evt[FLG_READY] = ready_evt;
      set_evt[FLG_ERR] = err_evt;
      state_next.flags = state_next.flags | set_evt;
      // reads answer from bus-side state without waiting
      if (rd_en)
      begin
         case (addr)
            OFF_CORE: state_next.rd_data = {state_reg.sh_half, state_reg.sh_high, state_reg.sh_low};
            OFF_CTRL:
            begin
               state_next.rd_data[CTRL_EN_BIT] = state_reg.sh_enable;
               state_next.rd_data[SOFT_RESET_BIT_BIT] = state_reg.sh_soft_reset_request;
            end
            OFF_PEND: state_next.rd_data[NCH-1:0] = state_reg.busy;
            OFF_FLAG: state_next.rd_data[NFLG-1:0] = state_reg.flags;
            OFF_MASK: state_next.rd_data[NFLG-1:0] = state_reg.mask;
            default: state_next.rd_data = '0;
         endcase
      end
      // level interrupt while an unmasked flag stands
      state_next.irq = |(state_next.flags & state_next.mask);
   end

   // state register with synchronous reset
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // outputs straight from flops
   assign rd_data = state_reg.rd_data;
   assign irq = state_reg.irq;
   assign core_byte_reg_low = state_reg.cr_low;
   assign core_byte_reg_high = state_reg.cr_high;
   assign core_halfword_reg = state_reg.cr_half;
   assign core_enable = state_reg.cr_enable;
   assign soft_reset_request = state_reg.reset_pulse;

   // helper: cycles the low byte channel has been busy
   logic [7:0] age_low;
   always_ff @(posedge clk)
   begin
      if (!rst_b || !state_reg.busy[CH_LOW])
      begin
         age_low <= 8'h00;
      end
      else
      begin
         age_low <= age_low + 8'h01;
      end
   end

   localparam int AMIN = SYNC_MIN_CYCLES;
   localparam int AMAX = SYNC_MAX_CYCLES;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_busy_on_write: assert property (
      (wr_en && addr == OFF_CORE && wr_be[0] && !state_reg.busy[CH_LOW] && !state_reg.busy[CH_SOFT_RESET_REQUEST])
      |=> state_reg.busy[CH_LOW] && state_reg.sh_low == $past(wr_data[7:0]))
      else $error("low byte write did not start its sync");

   a_sync_delay_window: assert property (
      ($fell(state_reg.busy[CH_LOW]) && !$past(done[CH_SOFT_RESET_REQUEST]))
      |-> (age_low >= AMIN) && (age_low <= AMAX))
      else $error("sync delay outside window");

   a_half_second_drop: assert property (
      (wr_en && addr == OFF_CORE && (wr_be[2] || wr_be[3]) && state_reg.busy[CH_HALF])
      |=> state_reg.flags[FLG_ERR] && $stable(state_reg.sh_half))
      else $error("write to busy halfword not discarded");

   a_half_keeps_bytes: assert property (
      (wr_en && addr == OFF_CORE && wr_be == 4'hC) |=> $stable(state_reg.sh_low) && $stable(state_reg.sh_high))
      else $error("halfword write disturbed byte registers");

   a_enable_readback: assert property (
      (wr_en && addr == OFF_CTRL && wr_be[0] && !state_reg.busy[CH_EN] && !state_reg.busy[CH_SOFT_RESET_REQUEST])
      |=> state_reg.busy[CH_EN] && state_reg.sh_enable == $past(wr_data[CTRL_EN_BIT]))
      else $error("enable does not read back new value");

   a_ready_source: assert property (
      $rose(state_reg.flags[FLG_READY])
      |-> |($past(state_reg.busy[CH_HALF:CH_LOW]) & ~state_reg.busy[CH_HALF:CH_LOW]))
      else $error("ready raised without a data register completing");

   a_soft_reset_request_zero_ignored: assert property (
      (wr_en && addr == OFF_CTRL && wr_be[0] && !wr_data[SOFT_RESET_BIT_BIT] && !state_reg.busy[CH_SOFT_RESET_REQUEST])
      |=> !state_reg.busy[CH_SOFT_RESET_REQUEST] && !state_reg.sh_soft_reset_request)
      else $error("zero write started a soft reset");

   a_soft_reset_request_one_start: assert property (
      (wr_en && addr == OFF_CTRL && wr_be[0] && wr_data[SOFT_RESET_BIT_BIT] && !state_reg.busy[CH_SOFT_RESET_REQUEST]
       && !state_reg.busy[CH_EN])
      |=> state_reg.busy[CH_SOFT_RESET_REQUEST] && state_reg.sh_soft_reset_request)
      else $error("soft reset write did not start");

   a_soft_reset_request_clears: assert property (
      $fell(state_reg.busy[CH_SOFT_RESET_REQUEST]) |-> !state_reg.sh_soft_reset_request && state_reg.reset_pulse && !state_reg.cr_enable)
      else $error("soft reset completion did not clear state");

   a_pend_readback: assert property (
      (rd_en && addr == OFF_PEND) |=> rd_data[NCH-1:0] == $past(state_reg.busy))
      else $error("pending flags not returned next cycle");
endmodule : rws_sync

// File: hw/rws_pkg.sv
package rws_pkg;
   // bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // register offsets (byte addresses, one word each)
   localparam logic [7:0] OFF_CORE = 8'h00;
   localparam logic [7:0] OFF_CTRL = 8'h04;
   localparam logic [7:0] OFF_PEND = 8'h08;
   localparam logic [7:0] OFF_FLAG = 8'h0C;
   localparam logic [7:0] OFF_MASK = 8'h10;
   // sync channel index, also the bit position in pending_sync_flags
   localparam int CH_SOFT_RESET_REQUEST = 0;
   localparam int CH_EN = 1;
   localparam int CH_LOW = 2;
   localparam int CH_HIGH = 3;
   localparam int CH_HALF = 4;
   localparam int NCH = 5;
   // bit positions in the control word
   localparam int SOFT_RESET_BIT_BIT = 0;
   localparam int CTRL_EN_BIT = 1;
   // bit positions in the interrupt flag and mask words
   localparam int FLG_READY = 0;
   localparam int FLG_ERR = 1;
   localparam int NFLG = 2;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_HALF = 16'h0000;
   localparam logic RST_ENABLE = 1'b0;
   // timing: bus clock and bench core clock periods
   localparam int CLK_PERIOD_NS = 40;
   localparam int CORE_PERIOD_NS = 320;
   // core clock rising edges counted before a sync completes
   localparam int SYNC_CORE_TICKS = 6;
   localparam logic [2:0] SYNC_LAST_TICK = 3'(SYNC_CORE_TICKS - 1);
   // documented delay window in core and bus periods
   localparam int SYNC_MIN_CORE = 5;
   localparam int SYNC_MIN_BUS = 2;
   localparam int SYNC_MAX_CORE = 6;
   localparam int SYNC_MAX_BUS = 3;
   localparam int CORE_CYCLES = CORE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int SYNC_MIN_CYCLES = SYNC_MIN_CORE * CORE_CYCLES + SYNC_MIN_BUS;
   localparam int SYNC_MAX_CYCLES = SYNC_MAX_CORE * CORE_CYCLES + SYNC_MAX_BUS;
endpackage : rws_pkg

// File: tb/rws_host.sv
`timescale 1ns/1ns
// bus host model: one-cycle strobes, idle lines show the inverse of the last value
module rws_host
   import rws_pkg::*;
(
   input wire logic clk,
   output logic wr_en,
   output logic rd_en,
   output logic [rws_pkg::ADDR_W-1:0] addr,
   output logic [rws_pkg::DATA_W-1:0] wr_data,
   output logic [3:0] wr_be,
   input wire logic [rws_pkg::DATA_W-1:0] rd_data
);
   // quiet bus at time zero
   initial
   begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 8'h00;
      wr_data = 32'h00000000;
      wr_be = 4'h0;
   end

   // write: strobe for one cycle beside address, data and lanes
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge clk);
      wr_en <= 1'b1;
      addr <= a;
      wr_data <= d;
      wr_be <= be;
      @(posedge clk);
      wr_en <= 1'b0;
      addr <= ~a;
      wr_data <= ~d;
      wr_be <= ~be;
   endtask : wr

   // read: strobe for one cycle, data taken at the edge closing the answer cycle
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      addr <= ~a;
      @(posedge clk);
      d = rd_data;
   endtask : rd
endmodule : rws_host

// File: tb/testbench.sv
`timescale 1ns/1ns
// compare one value, count and report
`define CHK(nm, exp, got) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
         error_cnt++; \
         $display("unexpected %s: expected %h seen %h", nm, exp, got); \
      end \
   end
module testbench;
   import rws_pkg::*;
   logic clk, rst_b, core_clk, wr_en, rd_en, irq, core_enable, soft_reset_request;
   logic [7:0] addr, core_byte_reg_low, core_byte_reg_high;
   logic [31:0] wr_data, rd_data;
   logic [3:0] wr_be;
   logic [15:0] core_halfword_reg;
   int error_cnt = 0;
   int samples_checked = 0;
   int cyc = 0; // bus edges seen
   int srst_cnt = 0; // soft reset completion pulses
   int t0, dt;

   rws_sync rws_sync_inst (.clk(clk), .rst_b(rst_b), .core_domain_clock(core_clk), .wr_en(wr_en),
      .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .wr_be(wr_be), .rd_data(rd_data), .irq(irq),
      .core_byte_reg_low(core_byte_reg_low), .core_byte_reg_high(core_byte_reg_high),
      .core_halfword_reg(core_halfword_reg), .core_enable(core_enable),
      .soft_reset_request(soft_reset_request));
   rws_host rws_host_inst (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
      .wr_be(wr_be), .rd_data(rd_data));

   // bus clock
   initial clk = 1'b0;
   always #(CLK_PERIOD_NS / 2) clk = ~clk;
   // core clock, free running and out of phase with the bus clock
   initial
   begin
      core_clk = 1'b0;
      #7;
      forever #(CORE_PERIOD_NS / 2) core_clk = ~core_clk;
   end
   // edge counter and pulse counter
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (soft_reset_request === 1'b1)
         srst_cnt <= srst_cnt + 1;
   end

   // read a register and compare
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
      logic [31:0] d;
      rws_host_inst.rd(a, d);
      `CHK(nm, exp, d)
   endtask : rdchk

   // poll the busy flags until every sync is done
   task automatic wait_idle();
      logic [31:0] p;
      int k;
      p = 32'hFFFFFFFF;
      k = 0;
      while (p !== 32'h00000000 && k < 100)
      begin
         rws_host_inst.rd(OFF_PEND, p);
         k++;
      end
      `CHK("pending idle", 32'h00000000, p)
   endtask : wait_idle

   // verdict and end of run
   task automatic finish_test();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test

   // watchdog against a hang
   initial
   begin
      #(CLK_PERIOD_NS * 20000);
      error_cnt++;
      finish_test();
   end

   // main sequence
   initial
   begin
      rst_b = 1'b0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      // reset values and unmapped address
      rdchk(OFF_CORE, 32'h00000000, "core word");
      rdchk(OFF_CTRL, 32'h00000000, "ctrl");
      rdchk(OFF_FLAG, 32'h00000000, "flags");
      rdchk(8'h14, 32'h00000000, "unmapped");
      rws_host_inst.wr(OFF_MASK, 32'h00000001, 4'h1);
      // neighbouring byte writes, each with its own sync and delay
      rws_host_inst.wr(OFF_CORE, 32'h000000A5, 4'h1);
      #1;
      t0 = cyc;
      rws_host_inst.wr(OFF_CORE, 32'h00005A00, 4'h2);
      rdchk(OFF_PEND, 32'h0000000C, "both bytes pending");
      rdchk(OFF_CORE, 32'h00005AA5, "immediate read");
      while (core_byte_reg_low !== 8'hA5 && cyc - t0 < 200)
      begin
         @(posedge clk);
         #1;
      end
      dt = cyc - t0;
      `CHK("sync delay in window", 1'b1, (dt >= SYNC_MIN_CYCLES && dt <= SYNC_MAX_CYCLES))
      wait_idle();
      `CHK("high byte", 8'h5A, core_byte_reg_high)
      rdchk(OFF_FLAG, 32'h00000001, "ready flag");
      `CHK("irq raised", 1'b1, irq)
      rws_host_inst.wr(OFF_FLAG, 32'h00000003, 4'h1);
      rdchk(OFF_FLAG, 32'h00000000, "flags cleared");
      `CHK("irq cleared", 1'b0, irq)
      // halfword write leaves the bytes alone
      rws_host_inst.wr(OFF_CORE, 32'h12340000, 4'hC);
      wait_idle();
      rdchk(OFF_CORE, 32'h12345AA5, "halfword word");
      `CHK("halfword copy", 16'h1234, core_halfword_reg)
      // halfword as two byte writes: second dropped with error
      rws_host_inst.wr(OFF_CORE, 32'h00770000, 4'h4);
      rws_host_inst.wr(OFF_CORE, 32'h88000000, 4'h8);
      wait_idle();
      rdchk(OFF_CORE, 32'h12775AA5, "split halfword");
      rdchk(OFF_FLAG, 32'h00000003, "error flag");
      rws_host_inst.wr(OFF_FLAG, 32'h00000003, 4'h1);
      // word write starts all three syncs
      rws_host_inst.wr(OFF_CORE, 32'hCAFE0102, 4'hF);
      rdchk(OFF_PEND, 32'h0000001C, "word pending");
      wait_idle();
      `CHK("core copies", 32'hCAFE0102, {core_halfword_reg, core_byte_reg_high, core_byte_reg_low})
      rws_host_inst.wr(OFF_FLAG, 32'h00000003, 4'h1);
      // enable write: busy, immediate readback, no ready flag
      rws_host_inst.wr(OFF_CTRL, 32'h00000002, 4'h1);
      rdchk(OFF_CTRL, 32'h00000002, "enable readback");
      #1;
      `CHK("read data one cycle", 32'h00000000, rd_data)
      rdchk(OFF_PEND, 32'h00000002, "enable pending only");
      wait_idle();
      `CHK("core enable", 1'b1, core_enable)
      rdchk(OFF_FLAG, 32'h00000000, "no ready for enable");
      `CHK("irq quiet", 1'b0, irq)
      // soft reset: reads one, busy, cleared by hardware, no ready flag
      rws_host_inst.wr(OFF_CTRL, 32'h00000003, 4'h1);
      rdchk(OFF_CTRL, 32'h00000003, "soft reset readback");
      rdchk(OFF_PEND, 32'h00000003, "soft reset pending");
      wait_idle();
      rdchk(OFF_CTRL, 32'h00000000, "soft reset cleared");
      rdchk(OFF_CORE, 32'h00000000, "core after reset");
      `CHK("reset pulses", 1, srst_cnt)
      `CHK("halfword after reset", 16'h0000, core_halfword_reg)
      rdchk(OFF_FLAG, 32'h00000000, "no ready for reset");
      finish_test();
   end
endmodule : testbench
